// file: design/nwpg_pkg.sv
// Shared constants, types and timing for the NAND write-protect host
package nwpg_pkg;

	// Clock period of core_clk
	localparam int CLK_NS = 4;

	// Pin timing in nanoseconds
	localparam int T_WW_NS = 100;
	localparam int T_WP_NS = 12;
	localparam int T_WC_NS = 25;
	localparam int T_ADL_NS = 70;
	localparam int T_WB_NS = 100;
	localparam int T_WHR_NS = 80;
	localparam int T_REA_NS = 22;
	localparam int T_REH_NS = 10;
	localparam int T_POWERUP_NS = 1000000;

	// Minimum time to cycles, rounded up, never below one
	function automatic int nwpg_ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction : nwpg_ns_to_cyc

	// Input synchroniser depth
	localparam int SYNC_STAGES = 2;

	// Cycle counts derived from the times above
	localparam int WW_CYC = nwpg_ns_to_cyc(T_WW_NS);
	localparam int WE_LO_CYC = nwpg_ns_to_cyc(T_WP_NS);
	localparam int WE_HI_CYC = nwpg_ns_to_cyc(T_WC_NS - T_WP_NS);
	localparam int ADL_CYC = nwpg_ns_to_cyc(T_ADL_NS);
	localparam int WB_CYC = nwpg_ns_to_cyc(T_WB_NS);
	localparam int WHR_CYC = nwpg_ns_to_cyc(T_WHR_NS);
	localparam int RE_LO_CYC = nwpg_ns_to_cyc(T_REA_NS) + SYNC_STAGES + 1;
	localparam int RE_HI_CYC = nwpg_ns_to_cyc(T_REH_NS);
	localparam int POWERUP_CYC = nwpg_ns_to_cyc(T_POWERUP_NS);

	// Page geometry
	localparam int PAGE_BYTES = 2112;
	localparam int LEN_W = 12;
	localparam int IO_W = 8;

	// Command opcodes
	localparam logic [7:0] CMD_ERASE1 = 8'h60;
	localparam logic [7:0] CMD_ERASE2 = 8'hd0;
	localparam logic [7:0] CMD_PROG1 = 8'h80;
	localparam logic [7:0] CMD_PROG2 = 8'h10;
	localparam logic [7:0] CMD_STATUS = 8'h70;

	// Status byte fields
	localparam int ST_READY_BIT = 5;
	localparam int ST_WPEN_BIT = 7;

	// Address cycle indices
	localparam logic [2:0] ADDR_FIRST_PROG = 3'h0;
	localparam logic [2:0] ADDR_FIRST_ERASE = 3'h2;
	localparam logic [2:0] ADDR_LAST = 3'h4;

	// Operations the host offers
	typedef enum logic [1:0] {
		OP_STATUS = 2'h0,
		OP_ERASE = 2'h1,
		OP_PROGRAM = 2'h2
	} nwpg_op_type;

	// One request from the user side
	typedef struct packed {
		nwpg_op_type op;
		logic wp_release;
		logic [15:0] col;
		logic [23:0] row;
		logic [LEN_W-1:0] len;
	} nwpg_req_type;

	// Pins toward the flash
	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic re_n;
		logic cle;
		logic ale;
		logic wp_n;
		logic [IO_W-1:0] io_out;
		logic io_oe;
	} nwpg_pins_type;

	// Pin levels after reset: deselected, write protected
	localparam nwpg_pins_type PINS_RESET = '{
		ce_n: 1'b1, we_n: 1'b1, re_n: 1'b1, cle: 1'b0, ale: 1'b0,
		wp_n: 1'b0, io_out: 8'h00, io_oe: 1'b0};

endpackage : nwpg_pkg

// file: design/nwpg_sync.sv
// Two-stage synchroniser for pins entering the core_clk domain
`timescale 1ns/100ps
`default_nettype none
module nwpg_sync #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			meta_q <= '0;
			sync_out <= '0;
		end else if (clk_en) begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : nwpg_sync
`default_nettype wire

// file: design/nwpg_host.sv
// Host controller driving a NAND flash program, erase and status sequence
// Notes on behaviour
// - The host sets write-protect before the first command is latched.
// - The host holds write-protect until status shows ready on bit 5.
// - The host waits at least 1 ms after power-up before any command.
// - The host keeps write-protect low during power-up and while idle.
`timescale 1ns/100ps
`default_nettype none
module nwpg_host #(
	parameter int POWERUP_CYCLES = nwpg_pkg::POWERUP_CYC
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic req_valid,
	input wire nwpg_pkg::nwpg_req_type req,
	output logic req_ready,
	input wire logic wr_valid,
	input wire logic [nwpg_pkg::IO_W-1:0] wr_data,
	output logic wr_ready,
	output logic done,
	output logic [nwpg_pkg::IO_W-1:0] status,
	output logic prot,
	output nwpg_pkg::nwpg_pins_type pins,
	input wire logic [nwpg_pkg::IO_W-1:0] io_in,
	input wire logic ry_by
);
	import nwpg_pkg::*;

	localparam int WAIT_MAX = (POWERUP_CYCLES > 255) ? POWERUP_CYCLES : 255;
	localparam int WAIT_W = $clog2(WAIT_MAX + 1);
	localparam logic [4:0] WE_LO = 5'(WE_LO_CYC);
	localparam logic [4:0] WR_LAST = 5'(WE_LO_CYC + WE_HI_CYC - 1);
	localparam logic [4:0] RE_LO = 5'(RE_LO_CYC);
	localparam logic [4:0] RD_LAST = 5'(RE_LO_CYC + RE_HI_CYC);

	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_WPSET = 4'h1,
		S_CMD1 = 4'h3,
		S_ADDR = 4'h2,
		S_DATA = 4'h6,
		S_CMD2 = 4'h7,
		S_BUSY = 4'h5,
		S_STCMD = 4'h4,
		S_STREAD = 4'hc,
		S_DONE = 4'hd,
		S_PWRUP = 4'h8
	} nwpg_state_type;

	nwpg_state_type state_q;
	nwpg_req_type req_q;
	logic [WAIT_W-1:0] wait_q;
	logic [4:0] cyc_q;
	logic [2:0] idx_q;
	logic [LEN_W-1:0] cnt_q;
	logic [IO_W-1:0] dout_q;
	logic [IO_W-1:0] io_s;
	logic ry_s;
	logic wait_zero;
	logic wr_state;
	logic step;
	logic rstep;
	logic accept;

	// Address byte for each address cycle
	function automatic logic [7:0] addr_byte(input nwpg_req_type r,
		input logic [2:0] i);
		case (i)
			3'h0: addr_byte = r.col[7:0];
			3'h1: addr_byte = r.col[15:8];
			3'h2: addr_byte = r.row[7:0];
			3'h3: addr_byte = r.row[15:8];
			default: addr_byte = r.row[23:16];
		endcase
	endfunction : addr_byte

	// Wait count cast to the counter width
	function automatic logic [WAIT_W-1:0] wcnt(input int c);
		return WAIT_W'(c);
	endfunction : wcnt

	// Pins from the flash pass two flip-flops first
	nwpg_sync #(
		.W(IO_W + 1)
	) u_sync (
		.core_clk(core_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.async_in({ry_by, io_in}),
		.sync_out({ry_s, io_s})
	);

	// Step conditions for write and read bus cycles
	assign wait_zero = (wait_q == '0);
	assign wr_state = (state_q == S_CMD1) || (state_q == S_ADDR) ||
		(state_q == S_CMD2) || (state_q == S_STCMD) ||
		((state_q == S_DATA) && !wr_ready);
	assign step = wr_state && wait_zero;
	assign rstep = (state_q == S_STREAD) && wait_zero;
	assign accept = wr_valid && wr_ready;

	// Sequencer
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_q <= S_PWRUP;
			wait_q <= '0;
			cyc_q <= '0;
			idx_q <= '0;
			cnt_q <= '0;
			req_q <= '0;
		end else if (clk_en) begin
			if (!wait_zero)
				wait_q <= wait_q - 1'b1;
			if (step)
				cyc_q <= (cyc_q == WR_LAST) ? 5'h00 : cyc_q + 5'h01;
			else if (rstep)
				cyc_q <= (cyc_q == RD_LAST) ? 5'h00 : cyc_q + 5'h01;
			case (state_q)
				S_PWRUP: begin
					if (wait_zero && cyc_q == 5'h00) begin
						wait_q <= wcnt(POWERUP_CYCLES - 1);
						cyc_q <= 5'h01;
					end else if (wait_zero)
						state_q <= S_IDLE;
				end
				S_IDLE: begin
					cyc_q <= '0;
					if (req_valid && req_ready) begin
						req_q <= req;
						if (req.op == OP_STATUS)
							state_q <= S_STCMD;
						else begin
							state_q <= S_WPSET;
							wait_q <= wcnt(WW_CYC);
						end
					end
				end
				S_WPSET: begin
					if (wait_zero)
						state_q <= S_CMD1;
				end
				S_CMD1: begin
					if (step && cyc_q == WR_LAST) begin
						state_q <= S_ADDR;
						idx_q <= (req_q.op == OP_ERASE) ?
							ADDR_FIRST_ERASE : ADDR_FIRST_PROG;
					end
				end
				S_ADDR: begin
					if (step && cyc_q == WR_LAST) begin
						idx_q <= idx_q + 3'h1;
						if (idx_q == ADDR_LAST && req_q.op == OP_PROGRAM) begin
							state_q <= S_DATA;
							wait_q <= wcnt(ADL_CYC);
							cnt_q <= '0;
						end else if (idx_q == ADDR_LAST)
							state_q <= S_CMD2;
					end
				end
				S_DATA: begin
					if (step && cyc_q == WR_LAST) begin
						cnt_q <= cnt_q + 1'b1;
						if (cnt_q == req_q.len - 1'b1)
							state_q <= S_CMD2;
					end
				end
				S_CMD2: begin
					if (step && cyc_q == WR_LAST) begin
						state_q <= S_BUSY;
						wait_q <= wcnt(WB_CYC);
					end
				end
				S_BUSY: begin
					// Blocked operations also end in ready
					if (wait_zero && ry_s)
						state_q <= S_STCMD;
				end
				S_STCMD: begin
					if (step && cyc_q == WR_LAST) begin
						state_q <= S_STREAD;
						wait_q <= wcnt(WHR_CYC);
					end
				end
				S_STREAD: begin
					// Keep polling until the ready bit is set; a status request stops after one read
					if (rstep && cyc_q == RD_LAST &&
						(req_q.op == OP_STATUS || status[ST_READY_BIT]))
						state_q <= S_DONE;
				end
				S_DONE: state_q <= S_IDLE;
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// Pin drive
	always_ff @(posedge core_clk) begin
		if (!resetn)
			pins <= PINS_RESET;
		else if (clk_en) begin
			pins.we_n <= !(step && cyc_q < WE_LO);
			pins.re_n <= !(rstep && cyc_q < RE_LO);
			if (step && cyc_q == 5'h00) begin
				pins.cle <= (state_q != S_ADDR) && (state_q != S_DATA);
				pins.ale <= (state_q == S_ADDR);
				pins.io_oe <= 1'b1;
				case (state_q)
					S_CMD1: pins.io_out <= (req_q.op == OP_ERASE) ?
						CMD_ERASE1 : CMD_PROG1;
					S_ADDR: pins.io_out <= addr_byte(req_q, idx_q);
					S_DATA: pins.io_out <= dout_q;
					S_CMD2: pins.io_out <= (req_q.op == OP_ERASE) ?
						CMD_ERASE2 : CMD_PROG2;
					default: pins.io_out <= CMD_STATUS;
				endcase
			end else if (rstep || state_q == S_BUSY) begin
				pins.cle <= 1'b0;
				pins.ale <= 1'b0;
				pins.io_oe <= 1'b0;
			end
			// Write-protect: low at power-up and idle, steady mid-operation
			case (state_q)
				S_PWRUP: pins.wp_n <= 1'b0;
				S_IDLE: pins.wp_n <= 1'b0;
				S_WPSET: pins.wp_n <= req_q.wp_release;
				S_DONE: pins.wp_n <= 1'b0;
				default: pins.wp_n <= pins.wp_n;
			endcase
			pins.ce_n <= (state_q == S_PWRUP) || (state_q == S_IDLE) ||
				(state_q == S_DONE) || (state_q == S_WPSET);
		end
	end

	// User handshakes and write data capture
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			req_ready <= 1'b0;
			wr_ready <= 1'b0;
			dout_q <= '0;
		end else if (clk_en) begin
			req_ready <= (state_q == S_PWRUP && wait_zero && cyc_q != 5'h00) ||
				(state_q == S_DONE) ||
				(state_q == S_IDLE && req_ready && !req_valid);
			if (accept) begin
				wr_ready <= 1'b0;
				dout_q <= wr_data;
			end else if (state_q == S_ADDR && step && cyc_q == WR_LAST &&
				idx_q == ADDR_LAST && req_q.op == OP_PROGRAM)
				wr_ready <= 1'b1;
			else if (state_q == S_DATA && step && cyc_q == WR_LAST &&
				cnt_q != req_q.len - 1'b1)
				wr_ready <= 1'b1;
		end
	end

	// Status capture and completion report
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			status <= '0;
			prot <= 1'b0;
			done <= 1'b0;
		end else if (clk_en) begin
			if (rstep && cyc_q == RE_LO)
				status <= io_s;
			done <= (state_q == S_DONE);
			if (state_q == S_DONE)
				prot <= (req_q.op != OP_STATUS) && !status[ST_WPEN_BIT];
		end
	end

	// Helpers for the checks below
	logic [7:0] wp_age_q;
	logic pwr_seen_q;
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			wp_age_q <= '0;
			pwr_seen_q <= 1'b0;
		end else if (clk_en) begin
			if (pins.wp_n != $past(pins.wp_n))
				wp_age_q <= 8'h01;
			else if (wp_age_q != 8'hff)
				wp_age_q <= wp_age_q + 8'h01;
			if (state_q == S_IDLE)
				pwr_seen_q <= 1'b1;
		end
	end

	property p_wp_setup;
		@(posedge core_clk) disable iff (!resetn)
		$rose(pins.we_n) && pins.cle && state_q == S_CMD1 |->
			wp_age_q >= 8'(WW_CYC);
	endproperty
	a_wp_setup: assert property (p_wp_setup)
		else $error("write-protect changed too close to first command");

	property p_wp_hold;
		@(posedge core_clk) disable iff (!resetn)
		$past(state_q) != S_WPSET && state_q inside {S_CMD1, S_ADDR,
			S_DATA, S_CMD2, S_BUSY, S_STCMD, S_STREAD} |->
			$stable(pins.wp_n);
	endproperty
	a_wp_hold: assert property (p_wp_hold)
		else $error("write-protect moved during an operation");

	property p_done_ready;
		@(posedge core_clk) disable iff (!resetn)
		$rose(done) && req_q.op != OP_STATUS |-> status[ST_READY_BIT];
	endproperty
	a_done_ready: assert property (p_done_ready)
		else $error("operation finished without ready status");

	property p_pwr_quiet;
		@(posedge core_clk) disable iff (!resetn)
		!pwr_seen_q |-> pins.ce_n && pins.we_n && !pins.wp_n;
	endproperty
	a_pwr_quiet: assert property (p_pwr_quiet)
		else $error("bus active before power-up recovery");

	property p_pwr_wp_low;
		@(posedge core_clk) disable iff (!resetn)
		state_q == S_PWRUP ##1 state_q == S_PWRUP |-> !pins.wp_n;
	endproperty
	a_pwr_wp_low: assert property (p_pwr_wp_low)
		else $error("write-protect not low during power-up");

	property p_prot_flag;
		@(posedge core_clk) disable iff (!resetn)
		state_q == S_DONE && clk_en && req_q.op != OP_STATUS |=>
			prot == !$past(status[ST_WPEN_BIT]) && done;
	endproperty
	a_prot_flag: assert property (p_prot_flag)
		else $error("protection flag disagrees with status bit 7");
endmodule : nwpg_host
`default_nettype wire

// file: bench/nwpg_flash_model.sv
// Behavioural NAND device answering program, erase and status sequences
`timescale 1ns/100ps
`default_nettype none
module nwpg_flash_model #(
	parameter int PWR_CYC = 20
) (
	input wire logic core_clk,
	input wire nwpg_pkg::nwpg_pins_type pins,
	input wire logic [7:0] io,
	input wire logic lock,
	output logic [7:0] io_drv,
	output logic ry_by,
	output int n_erase,
	output int n_prog,
	output int n_byte,
	output logic [7:0] last_byte,
	output int n_viol
);
	import nwpg_pkg::*;
	// One-time page size; no OTP opcode is decoded, so nothing reaches it
	localparam int OTP_PAGE_BYTES = 2112;
	logic we_q = 1'b1;
	logic re_q = 1'b1;
	logic [7:0] hold_q = 8'h00;
	logic [7:0] cmd_q = 8'h00;
	logic wp_lat = 1'b0;
	logic track = 1'b0;
	logic ok;
	int busy = 0;
	int t = 0;
	// Ready flag and pin outputs
	assign ry_by = (busy == 0);
	assign ok = pins.wp_n && !lock;
	// Status while read strobe low, else a pattern flipping every cycle
	assign io_drv = (!pins.ce_n && !pins.re_n) ?
		{pins.wp_n, ry_by, ry_by, 5'h00} : ~hold_q;
	initial begin
		n_erase = 0;
		n_prog = 0;
		n_byte = 0;
		n_viol = 0;
		last_byte = 8'h00;
	end
	// Latch commands and data on the rising write strobe
	always @(posedge core_clk) begin
		we_q <= pins.we_n;
		re_q <= pins.re_n;
		hold_q <= io;
		if (t < PWR_CYC) t <= t + 1;
		if (busy != 0) busy <= busy - 1;
		if (t < PWR_CYC && pins.wp_n === 1'b1) n_viol <= n_viol + 1;
		if (track && pins.wp_n !== wp_lat) n_viol <= n_viol + 1;
		if (pins.we_n && !we_q && !pins.ce_n) begin
			if (pins.cle) begin
				cmd_q <= io;
				if (t < PWR_CYC || !ry_by) n_viol <= n_viol + 1;
				if (io == CMD_ERASE1 || io == CMD_PROG1) begin
					wp_lat <= pins.wp_n;
					track <= 1'b1;
					n_byte <= 0;
				end
				// Blocked ops leave the array alone, short busy only
				if (io == CMD_ERASE2 || io == CMD_PROG2) begin
					busy <= ok ? 40 : 8;
				end
				if (ok && io == CMD_ERASE2) n_erase <= n_erase + 1;
				if (ok && io == CMD_PROG2) n_prog <= n_prog + 1;
			end else if (!pins.ale && cmd_q == CMD_PROG1) begin
				n_byte <= n_byte + 1;
				last_byte <= io;
			end
		end
		// Hold window closes after a ready status read
		if (pins.re_n && !re_q && cmd_q == CMD_STATUS && ry_by) begin
			track <= 1'b0;
		end
	end
endmodule : nwpg_flash_model
`default_nettype wire

// file: bench/nwpg_host_tb_top.sv
// Self-checking bench for the NAND write-protect host
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
	$display("[ERR] %0t mismatch %h %h", $time, a, b); end end
module nwpg_host_tb_top;
	import nwpg_pkg::*;
	localparam int PWR = 20;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic req_valid = 1'b0;
	nwpg_req_type req = '0;
	logic wr_valid = 1'b0;
	logic [7:0] wr_data = 8'h00;
	logic lock = 1'b0;
	logic clk_en = 1'b1;
	logic req_ready;
	logic wr_ready;
	logic done;
	logic prot;
	logic ry_by;
	logic [7:0] status;
	logic [7:0] io_drv;
	logic [7:0] io_w;
	logic [7:0] last_byte;
	nwpg_pins_type pins;
	int n_erase;
	int n_prog;
	int n_byte;
	int n_viol;
	int num_errors = 0;
	int checked = 0;
	// Clock and resolved io wire
	always #2 core_clk = ~core_clk;
	assign io_w = pins.io_oe ? pins.io_out : io_drv;
	nwpg_host #(.POWERUP_CYCLES(PWR)) dut (.core_clk(core_clk),
		.resetn(resetn), .clk_en(clk_en), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .wr_valid(wr_valid), .wr_data(wr_data),
		.wr_ready(wr_ready), .done(done), .status(status), .prot(prot),
		.pins(pins), .io_in(io_w), .ry_by(ry_by));
	nwpg_flash_model #(.PWR_CYC(PWR)) flash (.core_clk(core_clk),
		.pins(pins), .io(io_w), .lock(lock), .io_drv(io_drv), .ry_by(ry_by),
		.n_erase(n_erase), .n_prog(n_prog), .n_byte(n_byte),
		.last_byte(last_byte), .n_viol(n_viol));
	task automatic results;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results
	// One request, feeding program bytes until done
	task automatic run_op(input nwpg_op_type op, input logic wp,
		input int len);
		int n;
		int k;
		n = 0;
		k = 0;
		req.op = op;
		req.wp_release = wp;
		req.row = 24'h000123;
		req.len = len[LEN_W-1:0];
		while (!req_ready && k < 300) begin
			@(negedge core_clk);
			k++;
		end
		req_valid = 1'b1;
		@(negedge core_clk);
		req_valid = 1'b0;
		k = 0;
		while (!done && k < 40000) begin
			if (wr_valid) begin
				wr_valid = 1'b0;
				n++;
			end else if (wr_ready && n < len) begin
				wr_valid = 1'b1;
				wr_data = n[7:0];
			end
			@(negedge core_clk);
			k++;
		end
		`CHK(done, 1'b1)
	endtask : run_op
	// Reset values and power-up wait
	task automatic t_powerup;
		int k;
		k = 0;
		`CHK(pins, PINS_RESET)
		while (!req_ready && k < 300) begin
			@(negedge core_clk);
			k++;
		end
		`CHK(k >= PWR, 1'b1)
		`CHK(pins.wp_n, 1'b0)
	endtask : t_powerup
	// Clock enable low in idle: every pin and req_ready frozen
	task automatic t_freeze;
		nwpg_pins_type p;
		p = pins;
		clk_en = 1'b0;
		repeat (6) @(negedge core_clk);
		`CHK(pins, p)
		`CHK(req_ready, 1'b1)
		clk_en = 1'b1;
	endtask : t_freeze
	// Erase with and without write enable, then under block lock
	task automatic t_erase;
		int b;
		b = n_erase;
		run_op(OP_ERASE, 1'b0, 0);
		`CHK(status, 8'h60)
		`CHK(prot, 1'b1)
		`CHK(n_erase, b)
		run_op(OP_ERASE, 1'b1, 0);
		`CHK(status, 8'he0)
		`CHK(prot, 1'b0)
		`CHK(n_erase, b + 1)
		`CHK(pins.wp_n, 1'b0)
		lock = 1'b1;
		run_op(OP_ERASE, 1'b1, 0);
		`CHK(n_erase, b + 1)
		`CHK(status[ST_READY_BIT], 1'b1)
		lock = 1'b0;
	endtask : t_erase
	// Program of given length, then a protected attempt
	task automatic t_prog(input int len);
		int b;
		b = n_prog;
		run_op(OP_PROGRAM, 1'b1, len);
		`CHK(n_prog, b + 1)
		`CHK(n_byte, len)
		`CHK(last_byte, 8'(len - 1))
		run_op(OP_PROGRAM, 1'b0, 4);
		`CHK(n_prog, b + 1)
		`CHK(prot, 1'b1)
	endtask : t_prog
	// Watchdog
	initial begin
		#300us;
		num_errors++;
		$display("[ERR] %0t timeout", $time);
		results();
	end
	// Main sequence
	initial begin
		repeat (8) @(negedge core_clk);
		resetn = 1'b1;
		t_powerup();
		run_op(OP_STATUS, 1'b0, 0);
		`CHK(status, 8'h60)
		t_freeze();
		t_erase();
		t_prog(3);
		t_prog(PAGE_BYTES);
		`CHK(n_viol, 0)
		results();
	end
endmodule : nwpg_host_tb_top
`default_nettype wire
